// >>> rtl/usr_pkg.sv
package usr_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] USR_OFS_RXDATA  = 8'h00;
  localparam logic [7:0] USR_OFS_RXSTAT  = 8'h04;
  localparam logic [7:0] USR_OFS_TXSTAT  = 8'h08;
  localparam logic [7:0] USR_OFS_IRQFLAG = 8'h0C;
  localparam logic [7:0] USR_OFS_IRQEN   = 8'h10;
  localparam logic [7:0] USR_OFS_INTCTL  = 8'h14;
  localparam logic [7:0] USR_OFS_PORTDIR = 8'h18;
  localparam logic [7:0] USR_OFS_SLEEP   = 8'h1C;

  // Receive status/control field positions
  localparam int USR_RS_SERIAL_PORT_ENABLE  = 7;
  localparam int USR_RS_RX9   = 6;
  localparam int USR_RS_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int USR_RS_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int USR_RS_ADDRESS_DETECT_ENABLE = 3;
  localparam int USR_RS_FRAMING_ERROR_FLAG  = 2;
  localparam int USR_RS_OVERRUN_ERROR_FLAG  = 1;
  localparam int USR_RS_RECEIVED_NINTH_BIT  = 0;

  // Transmit status/control field positions
  localparam int USR_TS_CLOCK_SOURCE_SELECT = 7;
  localparam int USR_TS_SYNC = 4;

  // Interrupt control and flag positions
  localparam int USR_IC_GIE  = 7;
  localparam int USR_IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int USR_IF_RC   = 5;

  // Reset values
  localparam logic [7:0] USR_RST_RXSTAT  = 8'h00;
  localparam logic [7:0] USR_RST_TXSTAT  = 8'h02;
  localparam logic [7:0] USR_RST_IRQEN   = 8'h00;
  localparam logic [7:0] USR_RST_INTCTL  = 8'h00;
  localparam logic [7:0] USR_RST_PORTDIR = 8'hFF;

  // Writable bits of the status/control registers; cleared bits are read-only
  localparam logic [7:0] USR_RS_WMASK = 8'hF8;
  localparam logic [7:0] USR_TS_WMASK = 8'hF7;

  localparam logic [1:0] USR_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       bit9;
    logic [7:0] low;
  } usr_word_t;

  typedef struct packed {
    logic       enable;
    logic       nine;
    logic       clear;
  } usr_rxctl_t;

endpackage : usr_pkg

// >>> rtl/usr_fifo.sv
`timescale 1ns/1ps
module usr_fifo
  import usr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      clr,
  input  wire logic      push,
  input  usr_word_t      wdata,
  input  wire logic      pop,
  output usr_word_t      rdata,
  output logic           full,
  output logic           empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 1) begin : g_depth_check
    $error("usr_fifo depth must be at least one");
  end

  usr_word_t          mem_r [DEPTH];
  usr_word_t          mem_nxt [DEPTH];
  logic [AW-1:0]      rd_r, rd_nxt, wr_r, wr_nxt;
  logic [AW:0]        cnt_r, cnt_nxt;
  logic               do_push, do_pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  assign full    = (cnt_r == (AW+1)'(DEPTH));
  assign empty   = (cnt_r == '0);
  assign rdata   = mem_r[rd_r];
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  always_comb begin
    mem_nxt = mem_r;
    rd_nxt  = rd_r;
    wr_nxt  = wr_r;
    cnt_nxt = cnt_r;
    if (clr) begin
      rd_nxt  = '0;
      wr_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (do_push) begin
        mem_nxt[wr_r] = wdata;
        wr_nxt        = inc(wr_r);
      end
      if (do_pop) begin
        rd_nxt = inc(rd_r);
      end
      cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule : usr_fifo

// >>> rtl/usr_rx.sv
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module usr_rx
  import usr_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_line,
  output logic             irq,
  output logic             wake
);

  if (FIFO_DEPTH < 1) begin : g_depth_check
    $error("usr_rx fifo depth must be at least one");
  end

  // Registers
  logic [7:0]  rxstat_r, rxstat_nxt;
  logic [7:0]  txstat_r, txstat_nxt;
  logic [7:0]  irqen_r, irqen_nxt;
  logic [7:0]  intctl_r, intctl_nxt;
  logic [7:0]  portdir_r, portdir_nxt;
  logic        sleep_r, sleep_nxt;
  logic        receive_flag_r, receive_flag_nxt;
  logic        ninth_r, ninth_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic        irq_r, irq_nxt;
  logic        wake_r, wake_nxt;

  // AHB data phase
  logic        dph_r, dph_nxt;
  logic        dwr_r, dwr_nxt;
  logic [7:0]  dadr_r, dadr_nxt;

  // Synchronisers
  logic [1:0]  ck_s_r, dt_s_r;
  logic        ck_d_r;
  logic        ck_rise;

  // Shift engine
  logic [8:0]  shift_r, shift_nxt;
  logic [3:0]  bits_r, bits_nxt;
  logic        word_done;
  usr_word_t   word;

  // FIFO
  usr_word_t   f_rdata;
  logic        f_full, f_empty, f_pop, f_push;

  logic        rx_active, addr_ok, rd_data, wr_cycle;

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = irq_r;
  assign wake      = wake_r;

  function automatic logic valid_addr(input logic [7:0] a);
    valid_addr = (a[1:0] == 2'h0) && (a <= USR_OFS_SLEEP);
  endfunction : valid_addr

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_s_r <= 2'h0;
      dt_s_r <= 2'h0;
      ck_d_r <= 1'b0;
    end else begin
      ck_s_r <= {ck_s_r[0], serial_clock_in};
      dt_s_r <= {dt_s_r[0], serial_data_line};
      ck_d_r <= ck_s_r[1];
    end
  end

  assign ck_rise = ck_s_r[1] && !ck_d_r;

  // Receiver runs on port enable, sync mode, external clock, and continuous enable
  assign rx_active = rxstat_r[USR_RS_SERIAL_PORT_ENABLE] && txstat_r[USR_TS_SYNC]
                     && !txstat_r[USR_TS_CLOCK_SOURCE_SELECT] && rxstat_r[USR_RS_CONTINUOUS_RECEIVE_ENABLE];

  // Shift in one bit per external clock rising edge, LSB first
  always_comb begin
    shift_nxt = shift_r;
    bits_nxt  = bits_r;
    word_done = 1'b0;
    if (!rx_active) begin
      bits_nxt = 4'h0;
    end else if (ck_rise) begin
      if (rxstat_r[USR_RS_RX9]) begin
        shift_nxt = {dt_s_r[1], shift_r[8:1]};
      end else begin
        shift_nxt = {1'b0, dt_s_r[1], shift_r[7:1]};
      end
      if (bits_r == (rxstat_r[USR_RS_RX9] ? 4'h8 : 4'h7)) begin
        bits_nxt  = 4'h0;
        word_done = 1'b1;
      end else begin
        bits_nxt = bits_r + 4'h1;
      end
    end
  end

  assign word.bit9 = rxstat_r[USR_RS_RX9] ? shift_nxt[8] : 1'b0;
  assign word.low  = shift_nxt[7:0];
  assign f_push    = word_done && !f_full;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= 9'h000;
      bits_r  <= 4'h0;
    end else begin
      shift_r <= shift_nxt;
      bits_r  <= bits_nxt;
    end
  end

  usr_fifo #(
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (!rxstat_r[USR_RS_SERIAL_PORT_ENABLE]),
    .push    (f_push),
    .wdata   (word),
    .pop     (f_pop),
    .rdata   (f_rdata),
    .full    (f_full),
    .empty   (f_empty)
  );

  // Bus decode
  assign addr_ok  = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign wr_cycle = dph_r && dwr_r;
  assign rd_data  = addr_ok && !hwrite && (haddr[7:0] == USR_OFS_RXDATA);
  assign f_pop    = rd_data && !f_empty;

  always_comb begin
    dph_nxt     = addr_ok;
    dwr_nxt     = addr_ok && hwrite;
    dadr_nxt    = addr_ok ? haddr[7:0] : dadr_r;
    rxstat_nxt  = rxstat_r;
    txstat_nxt  = txstat_r;
    irqen_nxt   = irqen_r;
    intctl_nxt  = intctl_r;
    portdir_nxt = portdir_r;
    sleep_nxt   = sleep_r;
    ninth_nxt   = ninth_r;
    hrdata_nxt  = hrdata_r;
    if (wr_cycle && valid_addr(dadr_r)) begin
      unique case (dadr_r)
        USR_OFS_RXSTAT:  rxstat_nxt  = (rxstat_r & ~USR_RS_WMASK) | (hwdata[7:0] & USR_RS_WMASK);
        USR_OFS_TXSTAT:  txstat_nxt  = (txstat_r & ~USR_TS_WMASK) | (hwdata[7:0] & USR_TS_WMASK);
        USR_OFS_IRQEN:   irqen_nxt   = hwdata[7:0];
        USR_OFS_INTCTL:  intctl_nxt  = hwdata[7:0];
        USR_OFS_PORTDIR: portdir_nxt = hwdata[7:0];
        USR_OFS_SLEEP:   sleep_nxt   = hwdata[0];
        default: ;
      endcase
    end
    // Overrun clears when continuous receive is low; a new overrun wins
    if (!rxstat_nxt[USR_RS_CONTINUOUS_RECEIVE_ENABLE]) begin
      rxstat_nxt[USR_RS_OVERRUN_ERROR_FLAG] = 1'b0;
    end
    if (word_done && f_full) begin
      rxstat_nxt[USR_RS_OVERRUN_ERROR_FLAG] = 1'b1;
    end
    // Ninth bit tracks the word now at the FIFO head; holds once empty
    if (!f_empty) begin
      ninth_nxt = f_rdata.bit9;
    end
    rxstat_nxt[USR_RS_RECEIVED_NINTH_BIT] = ninth_nxt;
    rxstat_nxt[USR_RS_FRAMING_ERROR_FLAG] = 1'b0;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        USR_OFS_RXDATA:  hrdata_nxt = {24'h0, f_rdata.low};
        USR_OFS_RXSTAT:  hrdata_nxt = {24'h0, rxstat_r};
        USR_OFS_TXSTAT:  hrdata_nxt = {24'h0, txstat_r};
        USR_OFS_IRQFLAG: hrdata_nxt = {26'h0, receive_flag_r, 5'h0};
        USR_OFS_IRQEN:   hrdata_nxt = {24'h0, irqen_r};
        USR_OFS_INTCTL:  hrdata_nxt = {24'h0, intctl_r};
        USR_OFS_PORTDIR: hrdata_nxt = {24'h0, portdir_r};
        USR_OFS_SLEEP:   hrdata_nxt = {31'h0, sleep_r};
        default:         hrdata_nxt = 32'h0;
      endcase
    end
  end

  // Receive flag is set while the FIFO holds data, and is sticky until a read or a port disable empties it
  always_comb begin
    receive_flag_nxt = receive_flag_r;
    if (f_push) begin
      receive_flag_nxt = 1'b1;
    end else if (!f_empty && !(f_pop && (FIFO_DEPTH == 1 || receive_flag_r == 1'b0))) begin
      receive_flag_nxt = 1'b1;
    end else begin
      receive_flag_nxt = !f_empty && !f_pop;
    end
    irq_nxt  = receive_flag_nxt && irqen_r[USR_IF_RC] && intctl_r[USR_IC_GIE]
               && intctl_r[USR_IC_PERIPHERAL_IRQ_ENABLE];
    wake_nxt = sleep_r && receive_flag_nxt && irqen_r[USR_IF_RC];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r     <= 1'b0;
      dwr_r     <= 1'b0;
      dadr_r    <= 8'h00;
      rxstat_r  <= USR_RST_RXSTAT;
      txstat_r  <= USR_RST_TXSTAT;
      irqen_r   <= USR_RST_IRQEN;
      intctl_r  <= USR_RST_INTCTL;
      portdir_r <= USR_RST_PORTDIR;
      sleep_r   <= 1'b0;
      ninth_r   <= 1'b0;
      receive_flag_r    <= 1'b0;
      hrdata_r  <= 32'h0;
      irq_r     <= 1'b0;
      wake_r    <= 1'b0;
    end else begin
      dph_r     <= dph_nxt;
      dwr_r     <= dwr_nxt;
      dadr_r    <= dadr_nxt;
      rxstat_r  <= rxstat_nxt;
      txstat_r  <= txstat_nxt;
      irqen_r   <= irqen_nxt;
      intctl_r  <= intctl_nxt;
      portdir_r <= portdir_nxt;
      sleep_r   <= sleep_nxt;
      ninth_r   <= ninth_nxt;
      receive_flag_r    <= receive_flag_nxt;
      hrdata_r  <= hrdata_nxt;
      irq_r     <= irq_nxt;
      wake_r    <= wake_nxt;
    end
  end

  // Assertions
  sequence s_word_full;
    word_done && f_full;
  endsequence

  property p_overrun;
    @(posedge hclk) disable iff (!hresetn) s_word_full |=> rxstat_r[USR_RS_OVERRUN_ERROR_FLAG];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag not set");

  property p_keep_full;
    @(posedge hclk) disable iff (!hresetn)
      (word_done && f_full && !f_pop) |=> (f_full && $stable(f_rdata));
  endproperty
  a_keep_full: assert property (p_keep_full) else $error("full fifo changed on overrun");

  property p_overrun_error_flag_clear;
    @(posedge hclk) disable iff (!hresetn)
      (!rxstat_r[USR_RS_CONTINUOUS_RECEIVE_ENABLE] && !word_done) |=> !rxstat_r[USR_RS_OVERRUN_ERROR_FLAG];
  endproperty
  a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear) else $error("overrun not cleared");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn) f_push |=> receive_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("receive flag not set");

  property p_irq_gate;
    @(posedge hclk) disable iff (!hresetn) irq_r |-> $past(irqen_r[USR_IF_RC]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_idle;
    @(posedge hclk) disable iff (!hresetn) !rxstat_r[USR_RS_CONTINUOUS_RECEIVE_ENABLE] |-> !word_done;
  endproperty
  a_idle: assert property (p_idle) else $error("word while disabled");

  property p_ext_clock;
    @(posedge hclk) disable iff (!hresetn) txstat_r[USR_TS_CLOCK_SOURCE_SELECT] |=> bits_r == 4'h0;
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("shift with internal clock");

  property p_bit_step;
    @(posedge hclk) disable iff (!hresetn) (rx_active && !ck_rise) |=> $stable(bits_r);
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("bit count without clock");

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
      (sleep_r && f_push && irqen_r[USR_IF_RC] && $stable(irqen_r)) |=> wake_r;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on word");

  property p_receive_flag_clear;
    @(posedge hclk) disable iff (!hresetn) (f_empty && !f_push) |=> !receive_flag_r;
  endproperty
  a_receive_flag_clear: assert property (p_receive_flag_clear) else $error("receive flag left set");

  property p_irq_receive_flag;
    @(posedge hclk) disable iff (!hresetn) irq_r |-> receive_flag_r;
  endproperty
  a_irq_receive_flag: assert property (p_irq_receive_flag) else $error("irq without receive flag");

  property p_bit_count;
    @(posedge hclk) disable iff (!hresetn) (rx_active && ck_rise && !word_done) |=> (bits_r == $past(bits_r) + 4'h1);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bit not counted");

  property p_ninth_head;
    @(posedge hclk) disable iff (!hresetn) !f_empty |=> (rxstat_r[USR_RS_RECEIVED_NINTH_BIT] == $past(f_rdata.bit9));
  endproperty
  a_ninth_head: assert property (p_ninth_head) else $error("ninth bit not from head word");

  property p_read_head;
    @(posedge hclk) disable iff (!hresetn) (rd_data && !f_empty) |=> (hrdata_r[7:0] == $past(f_rdata.low));
  endproperty
  a_read_head: assert property (p_read_head) else $error("read data not head word");

endmodule : usr_rx

// >>> test/usr_sync_master_model.sv
`timescale 1ns/1ps
module usr_sync_master_model
  import usr_pkg::*;
(
  input  wire logic hclk,
  input  wire logic go,
  input  usr_word_t word,
  input  wire logic nine,
  output logic      sclk,
  output logic      sdata,
  output logic      busy
);
  logic [8:0] w;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge hclk);
      if (go) begin
        busy = 1'b1;
        w = word;
        #3;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          sdata = w[i];
          #80 sclk = 1'b1;
          #80 sclk = 1'b0;
        end
        // Released line shows the inverse of the last bit
        sdata = ~sdata;
        busy = 1'b0;
      end
    end
  end
endmodule : usr_sync_master_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_top
  import usr_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sclk;
  logic        sdata;
  logic        irq;
  logic        wake;
  logic        go;
  logic        nine;
  logic        busy;
  usr_word_t   word;
  int          bad_count;
  int          checked;

  usr_rx #(.FIFO_DEPTH(2)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_clock_in(sclk), .serial_data_line(sdata),
    .irq(irq), .wake(wake)
  );

  usr_sync_master_model i_master (
    .hclk(hclk), .go(go), .word(word), .nine(nine), .sclk(sclk), .sdata(sdata), .busy(busy)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= USR_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, {24'h0, e})
    `CHK(hresp, 1'b0)
  endtask : rd

  task automatic send(input logic [8:0] v, input logic n);
    word <= v;
    nine <= n;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    while (busy) @(posedge hclk);
    repeat (8) @(posedge hclk);
  endtask : send

  task automatic t_reset;
    rd(USR_OFS_RXSTAT, USR_RST_RXSTAT);
    rd(USR_OFS_TXSTAT, USR_RST_TXSTAT);
    rd(USR_OFS_IRQEN, USR_RST_IRQEN);
    rd(USR_OFS_INTCTL, USR_RST_INTCTL);
    rd(USR_OFS_PORTDIR, USR_RST_PORTDIR);
    rd(USR_OFS_IRQFLAG, 8'h00);
    wr(USR_OFS_PORTDIR, 8'h5A);
    rd(USR_OFS_PORTDIR, 8'h5A);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_basic;
    wr(USR_OFS_TXSTAT, 8'h10);
    wr(USR_OFS_RXSTAT, 8'h90);
    send(9'h0A5, 1'b0);
    rd(USR_OFS_IRQFLAG, 8'h20);
    `CHK(irq, 1'b0)
    rd(USR_OFS_RXDATA, 8'hA5);
    rd(USR_OFS_IRQFLAG, 8'h00);
    wr(USR_OFS_RXSTAT, 8'hF0);
    send(9'h13C, 1'b1);
    send(9'h0C5, 1'b1);
    rd(USR_OFS_RXSTAT, 8'hF1);
    rd(USR_OFS_RXDATA, 8'h3C);
    rd(USR_OFS_RXSTAT, 8'hF0);
    rd(USR_OFS_RXDATA, 8'hC5);
    wr(USR_OFS_RXSTAT, 8'h90);
    wr(USR_OFS_TXSTAT, 8'h90);
    send(9'h066, 1'b0);
    rd(USR_OFS_IRQFLAG, 8'h00);
    wr(USR_OFS_TXSTAT, 8'h00);
    send(9'h066, 1'b0);
    rd(USR_OFS_IRQFLAG, 8'h00);
    wr(USR_OFS_TXSTAT, 8'h10);
    $display("test basic done");
  endtask : t_basic

  task automatic t_irq;
    wr(USR_OFS_IRQEN, 8'h20);
    wr(USR_OFS_SLEEP, 8'h01);
    send(9'h0C3, 1'b0);
    `CHK({wake, irq}, 2'b10)
    wr(USR_OFS_INTCTL, 8'hC0);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b1)
    rd(USR_OFS_RXDATA, 8'hC3);
    repeat (2) @(posedge hclk);
    `CHK({wake, irq}, 2'b00)
    wr(USR_OFS_SLEEP, 8'h00);
    wr(USR_OFS_IRQEN, 8'h00);
    send(9'h011, 1'b0);
    `CHK(irq, 1'b0)
    rd(USR_OFS_RXDATA, 8'h11);
    $display("test irq done");
  endtask : t_irq

  task automatic t_overrun;
    send(9'h001, 1'b0);
    send(9'h002, 1'b0);
    send(9'h003, 1'b0);
    rd(USR_OFS_RXSTAT, 8'h92);
    rd(USR_OFS_RXDATA, 8'h01);
    rd(USR_OFS_RXDATA, 8'h02);
    wr(USR_OFS_RXSTAT, 8'h80);
    rd(USR_OFS_RXSTAT, 8'h80);
    wr(USR_OFS_RXSTAT, 8'h90);
    send(9'h05A, 1'b0);
    rd(USR_OFS_RXDATA, 8'h5A);
    send(9'h077, 1'b0);
    wr(USR_OFS_RXSTAT, 8'h10);
    wr(USR_OFS_RXSTAT, 8'h90);
    rd(USR_OFS_IRQFLAG, 8'h00);
    $display("test overrun done");
  endtask : t_overrun

  task automatic give_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    go = 1'b0;
    nine = 1'b0;
    word = '0;
    bad_count = 0;
    checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_basic();
    t_irq();
    t_overrun();
    give_verdict();
  end

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule : tb_top
